/* File: shared/fpec_pkg.sv */
package fpec_pkg;
   // Array geometry
   localparam int ARR_BYTES = 1024;
   localparam int SECT_BYTES = 256;
   localparam int PAGE_BYTES = 16;
   localparam int NUM_SECT = 4;
   localparam int AW = 10;
   // Program/erase duration, longest time rounds down
   localparam int OP_TIME_NS = 2000000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
   localparam int TMR_W = 17;
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_DATA = 12'h004;
   localparam logic [11:0] OFS_ADDR_LO = 12'h008;
   localparam logic [11:0] OFS_ADDR_HI = 12'h00C;
   localparam logic [11:0] OFS_CRC = 12'h010;
   localparam logic [11:0] OFS_SEC = 12'h014;
   localparam logic [11:0] OFS_CFG = 12'h018;
   // Control/status fields
   localparam int CMD_LSB = 0;
   localparam int BUSY_BIT = 4;
   localparam int REFUSED_BIT = 5;
   localparam int DONE_BIT = 6;
   // Command codes
   localparam logic [3:0] CMD_NONE = 4'h0;
   localparam logic [3:0] CMD_LOAD = 4'h1;
   localparam logic [3:0] CMD_PROG = 4'h2;
   localparam logic [3:0] CMD_ERB = 4'h3;
   localparam logic [3:0] CMD_ERP = 4'h4;
   localparam logic [3:0] CMD_ERS = 4'h5;
   localparam logic [3:0] CMD_ERC = 4'h6;
   localparam logic [3:0] CMD_CRCS = 4'h7;
   localparam logic [3:0] CMD_CRCA = 4'h8;
   localparam logic [3:0] CMD_CFGW = 4'h9;
   localparam logic [3:0] CMD_CFGE = 4'hA;
   localparam logic [3:0] CMD_READ = 4'hB;
   // Configuration byte slots
   localparam int NUM_CFG = 7;
   localparam logic [2:0] CFG_UCFG = 3'h0;
   localparam logic [2:0] CFG_BOOTSTAT = 3'h1;
   localparam logic [2:0] CFG_BOOTVEC = 3'h2;
   localparam logic [2:0] CFG_SEC0 = 3'h3;
   localparam int SEC_OPEN_BIT = 0;
   // Values
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   // Serial link framing
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam logic [3:0] REPLY_BITS = 4'h8;
   typedef enum logic [2:0] {
      FPEC_IDLE = 3'b001,
      FPEC_TIMED = 3'b010,
      FPEC_CRC = 3'b100
   } fpec_state_e;
endpackage

/* File: shared/fpec_crc_if.sv */
`timescale 1ns/1ps
interface fpec_crc_if;
   logic start;
   logic byte_valid;
   logic [7:0] data;
   logic [31:0] result;
   modport eng (input start, input byte_valid, input data, output result);
   modport ctl (output start, output byte_valid, output data, input result);
endinterface

/* File: design/fpec_crc.sv */
`timescale 1ns/1ps
module fpec_crc
   import fpec_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   fpec_crc_if.eng cif
);
   logic [31:0] crc;

   // One byte through the reflected polynomial
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // Running remainder, restarted by each accepted CRC command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc <= CRC_INIT;
      end else if (cif.start) begin
         crc <= CRC_INIT;
      end else if (cif.byte_valid) begin
         crc <= crc_byte(crc, cif.data);
      end
   end

   assign cif.result = ~crc;

   restart_crc_a: assert property (@(posedge pclk) disable iff (!presetn)
      cif.start |=> cif.result == 32'h00000000) else $error("crc not restarted");
endmodule

/* File: design/fpec_top.sv */
`timescale 1ns/1ps
module fpec_top
   import fpec_pkg::*;
#(
   parameter int OP_LEN = OP_CYCLES
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic code_req,
   input wire logic [AW-1:0] code_addr,
   output logic [7:0] code_rdata,
   output logic code_valid,
   output logic code_refused,
   input wire logic ser_mode,
   input wire logic ser_clk,
   input wire logic ser_dat_i,
   output logic ser_dat_o,
   output logic ser_dat_oe,
   output logic busy,
   output logic [7:0] user_config_byte,
   output logic boot_status,
   output logic [7:0] boot_vector
);
   fpec_state_e state;
   logic [7:0] flash [ARR_BYTES];
   logic [7:0] cfg_mem [NUM_CFG];
   logic [7:0] pbuf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pmask;
   logic [7:0] data_reg, addr_lo, addr_hi, user_cfg_q;
   logic cfg_latched, refused, done;
   logic [3:0] last_cmd, op_cmd;
   logic [AW-1:0] op_addr, crc_idx, crc_last;
   logic [7:0] op_data;
   logic [TMR_W-1:0] timer;
   logic [1:0] mode_sync;
   logic [2:0] sclk_sync;
   logic [1:0] sdat_sync;
   logic [4:0] bit_cnt;
   logic [23:0] frame_sh;
   logic frame_done;
   logic [3:0] reply_cnt;
   logic [7:0] reply_sh;
   logic apb_wr, ctrl_wr, req_valid, accept, ignored, op_fire, timed_cmd, crc_cmd;
   logic [3:0] req_cmd;
   logic [AW-1:0] req_addr;
   logic [7:0] req_data;
   logic sclk_rise, sclk_fall, ser_on;
   fpec_crc_if cif ();

   // A sector is open while its security byte keeps the open bit erased
   function automatic logic sect_secured(input logic [1:0] s);
      return ~cfg_mem[CFG_SEC0 + {1'b0, s}][SEC_OPEN_BIT];
   endfunction

   // Second and third stages only are read; first stage feeds the second alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_sync <= 2'h0;
         sclk_sync <= 3'h0;
         sdat_sync <= 2'h0;
      end else begin
         mode_sync <= {mode_sync[0], ser_mode};
         sclk_sync <= {sclk_sync[1:0], ser_clk};
         sdat_sync <= {sdat_sync[0], ser_dat_i};
      end
   end

   assign ser_on = mode_sync[1];
   assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
   assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];

   // Serial frame: command, address and data shifted in MSB first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt <= 5'h00;
         frame_sh <= 24'h000000;
         frame_done <= 1'b0;
      end else begin
         frame_done <= 1'b0;
         if (!ser_on) begin
            bit_cnt <= 5'h00;
         end else if (sclk_rise && reply_cnt == 4'h0) begin
            frame_sh <= {frame_sh[22:0], sdat_sync[1]};
            if (bit_cnt == FRAME_BITS - 5'h01) begin
               bit_cnt <= 5'h00;
               frame_done <= 1'b1;
            end else begin
               bit_cnt <= bit_cnt + 5'h01;
            end
         end
      end
   end

   // APB write strobe at the access edge
   assign apb_wr = psel & penable & pready & pwrite;
   assign ctrl_wr = apb_wr & (paddr == OFS_CTRL) & pstrb[0];

   // Request from either source; firmware is shut out in serial mode
   always_comb begin
      if (ser_on) begin
         req_valid = frame_done;
         req_cmd = frame_sh[23:20];
         req_addr = frame_sh[17:8];
         req_data = frame_sh[7:0];
      end else begin
         req_valid = ctrl_wr && pwdata[CMD_LSB +: 4] != CMD_NONE;
         req_cmd = pwdata[CMD_LSB +: 4];
         req_addr = {addr_hi[1:0], addr_lo};
         req_data = data_reg;
      end
   end

   assign accept = req_valid & (state == FPEC_IDLE);
   assign ignored = (req_valid & (state != FPEC_IDLE)) | (ctrl_wr & ser_on);
   assign timed_cmd = (req_cmd inside {CMD_PROG, CMD_ERB, CMD_ERP, CMD_ERS, CMD_ERC, CMD_CFGW, CMD_CFGE});
   assign crc_cmd = (req_cmd == CMD_CRCS) || (req_cmd == CMD_CRCA);
   assign op_fire = (state == FPEC_TIMED) && (timer == TMR_W'(OP_LEN - 1));
   assign busy = (state != FPEC_IDLE);

   // Operation sequencer with internal pulse timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= FPEC_IDLE;
         timer <= '0;
         op_cmd <= CMD_NONE;
         op_addr <= '0;
         op_data <= 8'h00;
         crc_idx <= '0;
         crc_last <= '0;
      end else begin
         unique case (state)
            FPEC_IDLE: begin
               if (accept && timed_cmd) begin
                  state <= FPEC_TIMED;
                  timer <= '0;
                  op_cmd <= req_cmd;
                  op_addr <= req_addr;
                  op_data <= req_data;
               end else if (accept && crc_cmd) begin
                  state <= FPEC_CRC;
                  crc_idx <= (req_cmd == CMD_CRCS) ? {req_addr[9:8], 8'h00} : '0;
                  crc_last <= (req_cmd == CMD_CRCS) ? {req_addr[9:8], 8'hFF} : {AW{1'b1}};
               end
            end
            FPEC_TIMED: begin
               timer <= timer + TMR_W'(1);
               if (op_fire) begin
                  state <= FPEC_IDLE;
               end
            end
            FPEC_CRC: begin
               crc_idx <= crc_idx + AW'(1);
               if (crc_idx == crc_last) begin
                  state <= FPEC_IDLE;
               end
            end
         endcase
      end
   end

   // CRC engine walks the selected range one byte a cycle
   assign cif.start = accept & crc_cmd;
   assign cif.byte_valid = (state == FPEC_CRC);
   assign cif.data = flash[crc_idx];

   fpec_crc i_fpec_crc (
      .pclk(pclk),
      .presetn(presetn),
      .cif(cif)
   );

   // Array update when the pulse timer expires
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < ARR_BYTES; i++) begin
            flash[i] <= ERASED;
         end
      end else if (op_fire) begin
         unique case (op_cmd)
            CMD_PROG: begin
               for (int i = 0; i < PAGE_BYTES; i++) begin
                  if (pmask[i]) begin
                     flash[{op_addr[9:4], 4'(i)}] <= flash[{op_addr[9:4], 4'(i)}] & pbuf[i];
                  end
               end
            end
            CMD_ERB: flash[op_addr] <= ERASED;
            CMD_ERP: begin
               for (int i = 0; i < PAGE_BYTES; i++) begin
                  flash[{op_addr[9:4], 4'(i)}] <= ERASED;
               end
            end
            CMD_ERS: begin
               for (int i = 0; i < SECT_BYTES; i++) begin
                  flash[{op_addr[9:8], 8'(i)}] <= ERASED;
               end
            end
            CMD_ERC: begin
               for (int i = 0; i < ARR_BYTES; i++) begin
                  flash[i] <= ERASED;
               end
            end
            default: ;
         endcase
      end
   end

   // Page buffer loads and empties after a page program
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pmask <= '0;
         for (int i = 0; i < PAGE_BYTES; i++) begin
            pbuf[i] <= ERASED;
         end
      end else if (accept && req_cmd == CMD_LOAD) begin
         pbuf[req_addr[3:0]] <= req_data;
         pmask[req_addr[3:0]] <= 1'b1;
      end else if (op_fire && op_cmd == CMD_PROG) begin
         pmask <= '0;
      end
   end

   // Config, boot and security bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_CFG; i++) begin
            cfg_mem[i] <= ERASED;
         end
      end else if (op_fire && op_addr[2:0] < 3'(NUM_CFG)) begin
         if (op_cmd == CMD_CFGW) begin
            cfg_mem[op_addr[2:0]] <= cfg_mem[op_addr[2:0]] & op_data;
         end else if (op_cmd == CMD_CFGE) begin
            cfg_mem[op_addr[2:0]] <= ERASED;
         end else if (op_cmd == CMD_ERC) begin
            for (int i = 0; i < NUM_SECT; i++) begin
               cfg_mem[CFG_SEC0 + 3'(i)] <= ERASED;
            end
         end
      end else if (op_fire && op_cmd == CMD_ERC) begin
         for (int i = 0; i < NUM_SECT; i++) begin
            cfg_mem[CFG_SEC0 + 3'(i)] <= ERASED;
         end
      end
   end

   assign boot_status = cfg_mem[CFG_BOOTSTAT][0];
   assign boot_vector = cfg_mem[CFG_BOOTVEC];

   // User config captured once after reset release, then frozen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_latched <= 1'b0;
         user_cfg_q <= 8'h00;
      end else if (!cfg_latched) begin
         cfg_latched <= 1'b1;
         user_cfg_q <= cfg_mem[CFG_UCFG];
      end
   end

   assign user_config_byte = user_cfg_q;

   // Code space read port, refused in secured sectors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_valid <= 1'b0;
         code_refused <= 1'b0;
         code_rdata <= 8'h00;
      end else begin
         code_valid <= code_req & ~sect_secured(code_addr[9:8]);
         code_refused <= code_req & sect_secured(code_addr[9:8]);
         code_rdata <= (code_req && !sect_secured(code_addr[9:8])) ? flash[code_addr] : 8'h00;
      end
   end

   // Firmware registers; a byte read lands in the data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_reg <= 8'h00;
         addr_lo <= 8'h00;
         addr_hi <= 8'h00;
         last_cmd <= CMD_NONE;
      end else begin
         if (accept && req_cmd == CMD_READ && !ser_on) begin
            data_reg <= sect_secured(req_addr[9:8]) ? 8'h00 : flash[req_addr];
         end else if (apb_wr && paddr == OFS_DATA && pstrb[0]) begin
            data_reg <= pwdata[7:0];
         end
         if (apb_wr && paddr == OFS_ADDR_LO && pstrb[0]) begin
            addr_lo <= pwdata[7:0];
         end
         if (apb_wr && paddr == OFS_ADDR_HI && pstrb[0]) begin
            addr_hi <= pwdata[7:0];
         end
         if (accept) begin
            last_cmd <= req_cmd;
         end
      end
   end

   // Sticky status: hardware set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refused <= 1'b0;
         done <= 1'b0;
      end else begin
         refused <= ignored | (refused & ~(ctrl_wr & pwdata[REFUSED_BIT]));
         done <= op_fire | (state == FPEC_CRC && crc_idx == crc_last) | (done & ~(ctrl_wr & pwdata[DONE_BIT]));
      end
   end

   // Serial read reply shifted out on falling clock edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reply_cnt <= 4'h0;
         reply_sh <= 8'h00;
      end else if (!ser_on) begin
         reply_cnt <= 4'h0;
      end else if (accept && req_cmd == CMD_READ) begin
         reply_cnt <= REPLY_BITS;
         reply_sh <= sect_secured(req_addr[9:8]) ? 8'h00 : flash[req_addr];
      end else if (sclk_fall && reply_cnt != 4'h0) begin
         reply_cnt <= reply_cnt - 4'h1;
         reply_sh <= {reply_sh[6:0], 1'b0};
      end
   end

   assign ser_dat_o = reply_sh[7];
   assign ser_dat_oe = (reply_cnt != 4'h0);

   // APB read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= 1'b0;
         unique case (paddr)
            OFS_CTRL: prdata <= {25'h0, done, refused, busy, last_cmd};
            OFS_DATA: prdata <= {24'h0, data_reg};
            OFS_ADDR_LO: prdata <= {24'h0, addr_lo};
            OFS_ADDR_HI: prdata <= {24'h0, addr_hi};
            OFS_CRC: prdata <= cif.result;
            OFS_SEC: prdata <= {28'h0, ~sect_secured(2'h3), ~sect_secured(2'h2), ~sect_secured(2'h1),
                                ~sect_secured(2'h0)};
            OFS_CFG: prdata <= {24'h0, user_cfg_q};
            default: begin
               prdata <= 32'h00000000;
               pslverr <= 1'b1;
            end
         endcase
      end
   end

   assign pready = 1'b1;

   // Checks
   logic [TMR_W-1:0] busy_len;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_len <= '0;
      end else begin
         busy_len <= (state == FPEC_TIMED) ? busy_len + TMR_W'(1) : '0;
      end
   end

   sequence s_launch;
      state == FPEC_IDLE && accept && timed_cmd;
   endsequence

   op_bound_a: assert property (@(posedge pclk) disable iff (!presetn) busy_len <= TMR_W'(OP_LEN))
      else $error("operation overran its time");
   launch_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_launch |=> busy && state == FPEC_TIMED) else $error("busy not raised");
   hold_op_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == FPEC_TIMED && !op_fire) |=> $stable(op_cmd) && $stable(op_addr)) else $error("op changed");
   byte_erase_a: assert property (@(posedge pclk) disable iff (!presetn)
      (op_fire && op_cmd == CMD_ERB) |=> flash[$past(op_addr)] == ERASED) else $error("byte not erased");
   chip_erase_a: assert property (@(posedge pclk) disable iff (!presetn)
      (op_fire && op_cmd == CMD_ERC) |=> flash[0] == ERASED && flash[ARR_BYTES-1] == ERASED)
      else $error("chip not erased");
   code_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
      (code_req && sect_secured(code_addr[9:8])) |=> code_refused && !code_valid && code_rdata == 8'h00)
      else $error("secured read leaked");
   cfg_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_latched |=> $stable(user_cfg_q)) else $error("config changed at run time");
   crc_walk_a: assert property (@(posedge pclk) disable iff (!presetn)
      (accept && req_cmd == CMD_CRCS) |=> state == FPEC_CRC ##255 state == FPEC_CRC ##1 state == FPEC_IDLE)
      else $error("sector crc length wrong");
   reply_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
      ser_dat_oe |-> ser_on) else $error("data driven outside serial mode");
   pbuf_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (op_fire && op_cmd == CMD_PROG) |=> pmask == '0) else $error("page buffer not emptied");
endmodule

/* File: verif/fpec_ser_prog.sv */
`timescale 1ns/1ps
module fpec_ser_prog (
   input wire logic pclk,
   output logic ser_clk,
   output logic ser_dat,
   input wire logic ser_dat_o,
   input wire logic ser_dat_oe
);
   // Byte read command code, the only frame that gets a reply
   localparam logic [3:0] CMD_RD = 4'hB;
   // Serial clock idles low between frames
   initial begin
      ser_clk = 1'b0;
      ser_dat = 1'b0;
   end
   // Each clock level is held four cycles
   task automatic hold();
      repeat (4) @(posedge pclk);
   endtask
   // One 24-bit frame sent MSB first, then an 8-bit reply for reads
   task automatic frame(input logic [3:0] cmd, input logic [9:0] a, input logic [7:0] d, output logic [7:0] rep);
      logic [23:0] f;
      int n;
      f = {cmd, 2'b00, a, d};
      rep = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         ser_dat <= f[i];
         hold();
         ser_clk <= 1'b1;
         hold();
         if (i > 0) ser_clk <= 1'b0;
      end
      n = 0;
      if (cmd == CMD_RD) begin
         ser_dat <= ~f[0]; // Released line shows the inverse
         while (ser_dat_oe !== 1'b1 && n < 20) begin
            @(posedge pclk);
            #1;
            n++;
         end
         @(posedge pclk);
         for (int i = 7; i >= 0; i--) begin
            rep[i] = ser_dat_o;
            ser_clk <= 1'b0;
            hold();
            if (i > 0) ser_clk <= 1'b1;
            hold();
         end
      end
      // Clock drops as the frame ends, so a timed operation is measured from its start
      ser_clk <= 1'b0;
   endtask
endmodule

/* File: verif/tb_fpec_top.sv */
`timescale 1ns/1ps
module tb_fpec_top;
   import fpec_pkg::*;
   localparam int OPL = 20;
   localparam logic W = 1'b1;
   localparam logic R = 1'b0;
   typedef struct {logic [11:0] ofs; logic wr; logic [7:0] dat; logic [7:0] exp; int len;} fpec_row_s;
   logic pclk, presetn, psel, penable, pwrite, code_req, ser_mode, ser_clk, ser_dat;
   logic pready, pslverr, code_valid, code_refused, sdo, sdoe, busy, bstat, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [AW-1:0] code_addr;
   logic [7:0] code_rdata, ucb, bvec, rep;
   int err_total, checks, cyc;
   fpec_row_s rows [27] = '{
      '{OFS_ADDR_LO,W,8'h23,0,0}, '{OFS_ADDR_HI,W,8'h01,0,0}, '{OFS_DATA,W,8'h5A,0,0},
      '{OFS_CTRL,W,CMD_LOAD,0,0}, '{OFS_CTRL,W,CMD_PROG,0,OPL}, '{OFS_CTRL,W,CMD_READ,0,0},
      '{OFS_DATA,R,0,8'h5A,0}, '{OFS_CTRL,W,CMD_ERB,0,OPL}, '{OFS_CTRL,W,CMD_READ,0,0},
      '{OFS_DATA,R,0,8'hFF,0}, '{OFS_ADDR_LO,W,8'h20,0,0}, '{OFS_DATA,W,8'h11,0,0},
      '{OFS_CTRL,W,CMD_LOAD,0,0}, '{OFS_ADDR_LO,W,8'h2F,0,0}, '{OFS_DATA,W,8'h22,0,0},
      '{OFS_CTRL,W,CMD_LOAD,0,0}, '{OFS_CTRL,W,CMD_PROG,0,OPL}, '{OFS_CTRL,W,CMD_READ,0,0},
      '{OFS_DATA,R,0,8'h22,0}, '{OFS_ADDR_LO,W,8'h20,0,0}, '{OFS_ADDR_LO,R,0,8'h20,0},
      '{OFS_CTRL,W,CMD_READ,0,0}, '{OFS_DATA,R,0,8'h11,0}, '{OFS_CTRL,W,CMD_ERP,0,OPL},
      '{OFS_CTRL,W,CMD_READ,0,0}, '{OFS_DATA,R,0,8'hFF,0}, '{OFS_ADDR_HI,R,0,8'h01,0}};

   fpec_top #(.OP_LEN(OPL)) i_fpec_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .code_req(code_req), .code_addr(code_addr), .code_rdata(code_rdata),
      .code_valid(code_valid), .code_refused(code_refused), .ser_mode(ser_mode), .ser_clk(ser_clk),
      .ser_dat_i(ser_dat), .ser_dat_o(sdo), .ser_dat_oe(sdoe), .busy(busy), .user_config_byte(ucb),
      .boot_status(bstat), .boot_vector(bvec));
   fpec_ser_prog i_fpec_ser_prog (.pclk(pclk), .ser_clk(ser_clk), .ser_dat(ser_dat), .ser_dat_o(sdo),
      .ser_dat_oe(sdoe));

   // Clock at 40 MHz
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 12000) begin
         err_total++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // One APB transfer; read data taken at the completing edge
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Waits for an operation and measures how long busy stands
   task automatic wait_op(input int len);
      int n;
      n = 0;
      #1;
      while (busy !== 1'b1 && n < 20) begin
         @(posedge pclk);
         #1;
         n++;
      end
      n = 0;
      while (busy === 1'b1 && n < 2000) begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (len > 0) chk(n, len, "op length");
   endtask
   task automatic cfg(input logic [7:0] slot, input logic [7:0] d, input logic [3:0] c);
      apb(OFS_ADDR_LO, W, slot);
      apb(OFS_DATA, W, d);
      apb(OFS_CTRL, W, c);
      wait_op(OPL);
   endtask
   task automatic code_rd(input logic [AW-1:0] a, input logic ok, input logic [7:0] d);
      @(posedge pclk);
      code_req <= 1'b1;
      code_addr <= a;
      @(posedge pclk);
      code_req <= 1'b0;
      #1;
      chk({code_valid, code_refused, code_rdata}, {ok, ~ok, d}, "code read");
   endtask
   function automatic logic [31:0] crc_ff(input int n);
      logic [31:0] c;
      c = CRC_INIT;
      for (int i = 0; i < 8 * n; i++) begin
         c = c ^ {31'h0, ~i[3] | i[3]};
         c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
      end
      return ~c;
   endfunction

   // Main sequence
   initial begin
      {psel, penable, pwrite, code_req, ser_mode} = '0;
      paddr = '0;
      pwdata = '0;
      code_addr = '0;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({busy, bstat, bvec, ucb}, {2'b01, 16'hFFFF}, "reset outputs");
      apb(OFS_SEC, R, 0);
      chk(rd, 32'h0F, "all open");
      apb(12'h01C, R, 0);
      chk({err, rd}, {1'b1, 32'h0}, "unmapped");
      $display("reset test done");
      foreach (rows[i]) begin
         apb(rows[i].ofs, rows[i].wr, rows[i].dat);
         if (rows[i].len > 0) wait_op(rows[i].len);
         if (!rows[i].wr) chk(rd, rows[i].exp, "table");
      end
      $display("table test done");
      apb(OFS_CTRL, W, CMD_CRCS);
      wait_op(0);
      apb(OFS_CRC, R, 0);
      chk(rd, crc_ff(SECT_BYTES), "crc sector");
      apb(OFS_CTRL, W, CMD_CRCA);
      wait_op(0);
      apb(OFS_CRC, R, 0);
      chk(rd, crc_ff(ARR_BYTES), "crc all");
      $display("crc test done");
      cfg(CFG_SEC0 + 1, 8'hFE, CMD_CFGW);
      apb(OFS_SEC, R, 0);
      chk(rd, 32'h0D, "secure one");
      code_rd(10'h123, 1'b0, 8'h00);
      code_rd(10'h020, 1'b1, 8'hFF);
      cfg(CFG_BOOTVEC, 8'h3C, CMD_CFGW);
      chk(bvec, 8'h3C, "boot vector");
      cfg(CFG_BOOTVEC, 8'h00, CMD_CFGE);
      cfg(CFG_UCFG, 8'h00, CMD_CFGW);
      apb(OFS_CFG, R, 0);
      chk({bvec, ucb, rd[7:0]}, 24'hFFFFFF, "config frozen");
      $display("security test done");
      apb(OFS_CTRL, W, CMD_ERS);
      apb(OFS_CTRL, W, CMD_CRCA);
      apb(OFS_CTRL, R, 0);
      chk(rd & 32'h3F, 32'h35, "busy refuse");
      wait_op(0);
      apb(OFS_CTRL, W, CMD_ERC);
      wait_op(OPL);
      apb(OFS_SEC, R, 0);
      chk(rd, 32'h0F, "chip erase");
      apb(OFS_CTRL, R, 0);
      chk(rd[6:4], 3'b110, "flags set");
      apb(OFS_CTRL, W, 32'h60);
      apb(OFS_CTRL, R, 0);
      chk(rd[6:4], 3'b000, "flags cleared");
      $display("busy test done");
      ser_mode <= 1'b1;
      repeat (4) @(posedge pclk);
      i_fpec_ser_prog.frame(CMD_LOAD, 10'h021, 8'hA5, rep);
      i_fpec_ser_prog.frame(CMD_PROG, 10'h021, 8'h00, rep);
      wait_op(OPL);
      i_fpec_ser_prog.frame(CMD_READ, 10'h021, 8'h00, rep);
      chk(rep, 8'hA5, "serial read");
      ser_mode <= 1'b0;
      $display("serial test done");
      test_done();
   end
endmodule
